// ### logic/rcar_arbiter.sv
// Remote control arbiter: control location, source selection, set value policy
//
// Function
// - Only analog or one digital source controls
// - Digital request refused while analog remote active
// - Remote pin ignored while digital holds control
// - Status and actual values readable at all times
// - Location is manual, remote or local
// - Remote disallowed: enter and show local state
// - Local ends digital session; host re-requests later
// - Local suspends analog; resumes if pin still low
// - Analog mode takes voltage, current, power together
// - Analog resistance only with resistance select pin
// - Protection thresholds never set from analog port
// - Shown set values follow analog inputs
// - Range setting selects 5 V or 10 V
// - Over-range analog input saturates at full nominal
// - Remote pin first; standby pin always acts
// - 26214 steps at 10 V, half at 5 V
// - Analog inputs and pins sampled at 500 Hz
// - Standby high-low-high, 50 ms low, acknowledges alarms in analog mode
// - Alarm in analog mode switches input off
`timescale 1ns/1ns
module rcar_arbiter #(
    parameter int unsigned SAMPLE_CYCLES = rcar_pkg::SAMPLE_CYCLES_DEF,
    parameter int unsigned ACK_LOW_CYCLES = rcar_pkg::ACK_LOW_CYCLES_DEF
) (
    input logic MCLK,
    input logic RST,
    // AHB-Lite slave
    input logic HSEL,
    input logic [31:0] HADDR,
    input logic [1:0] HTRANS,
    input logic HWRITE,
    input logic [2:0] HSIZE,
    input logic [31:0] HWDATA,
    input logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Analog control port pins, digital levels
    input logic REMOTE_SELECT_N,
    input logic RESISTANCE_MODE_N,
    input logic INPUT_STANDBY_PIN,
    // Converted analog set inputs, same clock
    input logic [15:0] VOLTAGE_SETPOINT_INPUT,
    input logic [15:0] CURRENT_SETPOINT_INPUT,
    input logic [15:0] POWER_SETPOINT_INPUT,
    input logic [15:0] RESISTANCE_SETPOINT_INPUT,
    // Actual values on the nominal scale, same clock
    input logic [15:0] ACTUAL_VOLTAGE,
    input logic [15:0] ACTUAL_CURRENT,
    // Alarm sources from the power stage supervision
    input logic [2:0] ALARM_OV_OC_OP,
    input logic ALARM_OT_PF,
    // Results
    output rcar_pkg::rcar_loc_t LOCATION,
    output logic ANALOG_ACTIVE,
    output logic DIGITAL_ACTIVE,
    output logic DIGITAL_REQ_ERROR,
    output logic R_MODE,
    output logic [15:0] VOLTAGE_SET,
    output logic [15:0] CURRENT_SET,
    output logic [15:0] POWER_SET,
    output logic [15:0] RESISTANCE_SET,
    output logic [15:0] OVERVOLTAGE_PROTECTION,
    output logic [15:0] VOLTAGE_MONITOR_OUTPUT,
    output logic [15:0] CURRENT_MONITOR_OUTPUT,
    output logic [15:0] REFERENCE_OUTPUT,
    output logic DC_INPUT_ON,
    output logic ALARM_OT_PF_OUT,
    output logic ALARM_OV_OC_OP_OUT
);
    import rcar_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [6:0] pin_meta_reg;
    logic [6:0] pin_sync_reg;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic remote_n_smp_reg;
    logic rmode_n_smp_reg;
    logic standby_smp_reg;
    logic standby_prev_reg;
    logic [31:0] low_cnt_reg;
    logic ack_pulse_reg;
    logic allow_reg;
    logic range10_reg;
    logic dc_on_req_reg;
    logic [15:0] loc_vset_reg;
    logic [15:0] loc_iset_reg;
    logic [15:0] loc_pset_reg;
    logic [15:0] loc_rset_reg;
    logic [2:0] alarm_lat_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rd_next;
    logic [15:0] adc_code [4];
    logic [15:0] scaled [4];
    logic rd_acc;
    logic wr_acc;
    logic cmd_wr;
    logic cmd_req;
    logic cmd_rel;
    logic cmd_ack;
    logic analog_want;
    logic alarm_clr;
    logic ovp_wr;

    // ----------------------------------------------------------------
    // Pin synchronisers and the sample tick
    // ----------------------------------------------------------------

    // Two flops before anything looks at a pin
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pin_meta_reg <= 7'h07;
            pin_sync_reg <= 7'h07;
        end else begin
            pin_meta_reg <= {ALARM_OT_PF, ALARM_OV_OC_OP, INPUT_STANDBY_PIN, RESISTANCE_MODE_N, REMOTE_SELECT_N};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Sample tick caps the acquisition rate
    always_ff @(posedge MCLK) begin
        if (RST) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg >= SAMPLE_CYCLES - 1) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    // Control pin states taken only at the tick; idle levels at reset mean no remote
    always_ff @(posedge MCLK) begin
        if (RST) begin
            remote_n_smp_reg <= 1'b1;
            rmode_n_smp_reg <= 1'b1;
            standby_smp_reg <= 1'b1;
        end else if (tick_reg) begin
            remote_n_smp_reg <= pin_sync_reg[0];
            rmode_n_smp_reg <= pin_sync_reg[1];
            standby_smp_reg <= pin_sync_reg[2];
        end
    end

    assign analog_want = ~remote_n_smp_reg;

    // ----------------------------------------------------------------
    // Analog set inputs
    // ----------------------------------------------------------------
    assign adc_code[0] = VOLTAGE_SETPOINT_INPUT;
    assign adc_code[1] = CURRENT_SETPOINT_INPUT;
    assign adc_code[2] = POWER_SETPOINT_INPUT;
    assign adc_code[3] = RESISTANCE_SETPOINT_INPUT;

    for (genvar g = 0; g < 4; g++) begin : g_scale
        rcar_setpoint_scale u_scale (
            .clk(MCLK),
            .rst(RST),
            .sample(tick_reg),
            .range10(range10_reg),
            .code(adc_code[g]),
            .value_reg(scaled[g])
        );
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    assign rd_acc = HSEL & HTRANS[1] & HREADY & ~HWRITE;
    assign wr_acc = HSEL & HTRANS[1] & HREADY & HWRITE;
    assign cmd_wr = wr_pend_reg && (wr_addr_reg == REG_CMD);
    assign cmd_req = cmd_wr & HWDATA[CMD_REQ_BIT];
    assign cmd_rel = cmd_wr & HWDATA[CMD_REL_BIT];
    assign cmd_ack = cmd_wr & HWDATA[CMD_ACK_BIT];
    assign ovp_wr = wr_pend_reg && (wr_addr_reg == REG_OVP);

    // Zero wait states, always OKAY
    always_ff @(posedge MCLK) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            wr_pend_reg <= wr_acc;
            wr_addr_reg <= HADDR[7:0];
        end
    end

    // Read mux; status and actual values answer in every location
    always_comb begin
        rd_next = 32'h0000_0000;
        case (HADDR[7:0])
            REG_CTRL: rd_next = {29'h0, dc_on_req_reg, range10_reg, allow_reg};
            REG_STATUS: rd_next = {20'h0, ALARM_OT_PF_OUT, alarm_lat_reg, 1'b0, R_MODE, DC_INPUT_ON,
                DIGITAL_REQ_ERROR, DIGITAL_ACTIVE, ANALOG_ACTIVE, LOCATION};
            REG_LOC_VSET: rd_next = {16'h0, loc_vset_reg};
            REG_LOC_ISET: rd_next = {16'h0, loc_iset_reg};
            REG_LOC_PSET: rd_next = {16'h0, loc_pset_reg};
            REG_LOC_RSET: rd_next = {16'h0, loc_rset_reg};
            REG_OVP: rd_next = {16'h0, OVERVOLTAGE_PROTECTION};
            REG_ACT_VI: rd_next = {CURRENT_SET, VOLTAGE_SET};
            REG_ACT_PR: rd_next = {RESISTANCE_SET, POWER_SET};
            REG_MON: rd_next = {ACTUAL_CURRENT, ACTUAL_VOLTAGE};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Read data is ready for the data phase
    always_ff @(posedge MCLK) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (rd_acc) begin
            HRDATA <= rd_next;
        end
    end

    // Register writes in the data phase
    always_ff @(posedge MCLK) begin
        if (RST) begin
            allow_reg <= ALLOW_RESET;
            range10_reg <= RANGE10_RESET;
            dc_on_req_reg <= DC_ON_RESET;
            loc_vset_reg <= SET_RESET;
            loc_iset_reg <= SET_RESET;
            loc_pset_reg <= SET_RESET;
            loc_rset_reg <= SET_RESET;
            OVERVOLTAGE_PROTECTION <= OVP_RESET;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                REG_CTRL: begin
                    allow_reg <= HWDATA[CTRL_ALLOW_BIT];
                    range10_reg <= HWDATA[CTRL_RANGE10_BIT];
                    dc_on_req_reg <= HWDATA[CTRL_DC_ON_BIT];
                end
                REG_LOC_VSET: loc_vset_reg <= HWDATA[15:0];
                REG_LOC_ISET: loc_iset_reg <= HWDATA[15:0];
                REG_LOC_PSET: loc_pset_reg <= HWDATA[15:0];
                REG_LOC_RSET: loc_rset_reg <= HWDATA[15:0];
                REG_OVP: OVERVOLTAGE_PROTECTION <= HWDATA[15:0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control location and source arbitration
    // ----------------------------------------------------------------

    // Analog wins a tie with a digital request in manual
    always_ff @(posedge MCLK) begin
        if (RST) begin
            LOCATION <= LOC_MANUAL;
            ANALOG_ACTIVE <= 1'b0;
            DIGITAL_ACTIVE <= 1'b0;
        end else if (!allow_reg) begin
            LOCATION <= LOC_LOCAL;
            DIGITAL_ACTIVE <= 1'b0;
            ANALOG_ACTIVE <= 1'b0;
        end else begin
            case (LOCATION)
                LOC_LOCAL: begin
                    if (analog_want) begin
                        LOCATION <= LOC_REMOTE;
                        ANALOG_ACTIVE <= 1'b1;
                    end else begin
                        LOCATION <= LOC_MANUAL;
                    end
                end
                LOC_MANUAL: begin
                    if (analog_want) begin
                        LOCATION <= LOC_REMOTE;
                        ANALOG_ACTIVE <= 1'b1;
                    end else if (cmd_req) begin
                        LOCATION <= LOC_REMOTE;
                        DIGITAL_ACTIVE <= 1'b1;
                    end
                end
                LOC_REMOTE: begin
                    if (DIGITAL_ACTIVE) begin
                        if (cmd_rel) begin
                            LOCATION <= LOC_MANUAL;
                            DIGITAL_ACTIVE <= 1'b0;
                        end
                    end else if (!analog_want) begin
                        LOCATION <= LOC_MANUAL;
                        ANALOG_ACTIVE <= 1'b0;
                    end
                end
                default: begin
                    LOCATION <= LOC_MANUAL;
                    ANALOG_ACTIVE <= 1'b0;
                    DIGITAL_ACTIVE <= 1'b0;
                end
            endcase
        end
    end

    // Refusal flag; a new refusal wins over a clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (RST) begin
            DIGITAL_REQ_ERROR <= 1'b0;
        end else if (cmd_req && (!allow_reg || LOCATION == LOC_LOCAL || ANALOG_ACTIVE || analog_want)) begin
            DIGITAL_REQ_ERROR <= 1'b1;
        end else if (wr_pend_reg && wr_addr_reg == REG_STATUS && HWDATA[STATUS_REFUSED_BIT]) begin
            DIGITAL_REQ_ERROR <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Set values in force
    // ----------------------------------------------------------------

    // All three come from one source, never a mix
    always_ff @(posedge MCLK) begin
        if (RST) begin
            VOLTAGE_SET <= SET_RESET;
            CURRENT_SET <= SET_RESET;
            POWER_SET <= SET_RESET;
            RESISTANCE_SET <= SET_RESET;
            R_MODE <= 1'b0;
        end else begin
            VOLTAGE_SET <= ANALOG_ACTIVE ? scaled[0] : loc_vset_reg;
            CURRENT_SET <= ANALOG_ACTIVE ? scaled[1] : loc_iset_reg;
            POWER_SET <= ANALOG_ACTIVE ? scaled[2] : loc_pset_reg;
            R_MODE <= ANALOG_ACTIVE & ~rmode_n_smp_reg;
            RESISTANCE_SET <= (ANALOG_ACTIVE && !rmode_n_smp_reg) ? scaled[3] : loc_rset_reg;
        end
    end

    // Monitor and reference codes follow the selected range
    always_ff @(posedge MCLK) begin
        if (RST) begin
            VOLTAGE_MONITOR_OUTPUT <= SET_RESET;
            CURRENT_MONITOR_OUTPUT <= SET_RESET;
            REFERENCE_OUTPUT <= STEPS_10V;
        end else begin
            VOLTAGE_MONITOR_OUTPUT <= rcar_to_range(ACTUAL_VOLTAGE, range10_reg);
            CURRENT_MONITOR_OUTPUT <= rcar_to_range(ACTUAL_CURRENT, range10_reg);
            REFERENCE_OUTPUT <= range10_reg ? STEPS_10V : STEPS_5V;
        end
    end

    // ----------------------------------------------------------------
    // Standby pin, alarms and the DC input
    // ----------------------------------------------------------------

    // Low phase length of the standby pin; saturates instead of wrapping
    always_ff @(posedge MCLK) begin
        if (RST) begin
            low_cnt_reg <= 32'h0000_0000;
            standby_prev_reg <= 1'b1;
            ack_pulse_reg <= 1'b0;
        end else begin
            standby_prev_reg <= standby_smp_reg;
            ack_pulse_reg <= standby_smp_reg && !standby_prev_reg && (low_cnt_reg >= ACK_LOW_CYCLES);
            if (standby_smp_reg) begin
                low_cnt_reg <= 32'h0000_0000;
            end else if (low_cnt_reg != 32'hffff_ffff) begin
                low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Pin acknowledge counts in analog mode, software acknowledge otherwise
    assign alarm_clr = (ack_pulse_reg && ANALOG_ACTIVE) || (cmd_ack && !ANALOG_ACTIVE);

    // Latched alarms; a live alarm source wins over the acknowledge
    always_ff @(posedge MCLK) begin
        if (RST) begin
            alarm_lat_reg <= 3'h0;
            ALARM_OV_OC_OP_OUT <= 1'b0;
            ALARM_OT_PF_OUT <= 1'b0;
        end else begin
            alarm_lat_reg <= (alarm_clr ? 3'h0 : alarm_lat_reg) | pin_sync_reg[5:3];
            ALARM_OV_OC_OP_OUT <= |alarm_lat_reg;
            ALARM_OT_PF_OUT <= pin_sync_reg[6];
        end
    end

    // Standby pin switches off in every location; alarms force off
    always_ff @(posedge MCLK) begin
        if (RST) begin
            DC_INPUT_ON <= 1'b0;
        end else begin
            DC_INPUT_ON <= standby_smp_reg && !(|alarm_lat_reg) && !pin_sync_reg[6]
                && (ANALOG_ACTIVE || dc_on_req_reg);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    one_source_a: assert property (@(posedge MCLK) disable iff (RST)
        !(ANALOG_ACTIVE && DIGITAL_ACTIVE))
        else $error("analog and digital control granted together");

    refuse_analog_a: assert property (@(posedge MCLK) disable iff (RST)
        cmd_req && ANALOG_ACTIVE |=> DIGITAL_REQ_ERROR && !DIGITAL_ACTIVE)
        else $error("digital request not refused under analog control");

    pin_ignored_a: assert property (@(posedge MCLK) disable iff (RST)
        DIGITAL_ACTIVE && allow_reg && !cmd_rel |=> DIGITAL_ACTIVE && !ANALOG_ACTIVE)
        else $error("remote pin disturbed a digital session");

    status_read_a: assert property (@(posedge MCLK) disable iff (RST)
        rd_acc && HADDR[7:0] == REG_STATUS |=> HRDATA[3:2] == $past({DIGITAL_ACTIVE, ANALOG_ACTIVE}))
        else $error("status readback does not match source state");

    local_enter_a: assert property (@(posedge MCLK) disable iff (RST)
        !allow_reg |=> LOCATION == LOC_LOCAL && !DIGITAL_ACTIVE && !ANALOG_ACTIVE)
        else $error("local lockout not entered");

    analog_resume_a: assert property (@(posedge MCLK) disable iff (RST)
        LOCATION == LOC_LOCAL && allow_reg && analog_want |=> ANALOG_ACTIVE && LOCATION == LOC_REMOTE)
        else $error("analog control did not resume after local");

    analog_set_a: assert property (@(posedge MCLK) disable iff (RST)
        ANALOG_ACTIVE |=> VOLTAGE_SET == $past(scaled[0]) && CURRENT_SET == $past(scaled[1])
            && POWER_SET == $past(scaled[2]))
        else $error("analog set values mixed with local ones");

    ovp_hold_a: assert property (@(posedge MCLK) disable iff (RST)
        !ovp_wr |=> $stable(OVERVOLTAGE_PROTECTION))
        else $error("protection level changed without a register write");

    ack_low_a: assert property (@(posedge MCLK) disable iff (RST)
        $rose(ack_pulse_reg) |-> $past(low_cnt_reg) >= ACK_LOW_CYCLES)
        else $error("alarm acknowledge after too short a low phase");

    alarm_off_a: assert property (@(posedge MCLK) disable iff (RST)
        |alarm_lat_reg |=> !DC_INPUT_ON)
        else $error("DC input stayed on during an alarm");

endmodule // rcar_arbiter

// ### logic/rcar_pkg.sv
// Shared constants, register map and helpers of the remote control arbiter
package rcar_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned SAMPLE_RATE_HZ = 500;
    // Least interval between two samples, rounded up
    localparam int unsigned SAMPLE_CYCLES_DEF = (CLK_FREQ_HZ + SAMPLE_RATE_HZ - 1) / SAMPLE_RATE_HZ;
    localparam int unsigned ACK_LOW_MS = 50;
    // Least low phase of the acknowledge pulse, rounded up
    localparam longint unsigned ACK_LOW_CYCLES_L = (longint'(ACK_LOW_MS) * CLK_FREQ_HZ + 999) / 1000;
    localparam int unsigned ACK_LOW_CYCLES_DEF = 32'(ACK_LOW_CYCLES_L);

    // ----------------------------------------------------------------
    // Quantisation: 26214 steps in the 10 V range, half in the 5 V range
    // ----------------------------------------------------------------
    localparam int unsigned SET_W = 16;
    localparam logic [15:0] STEPS_10V = 16'h6666;
    localparam logic [15:0] STEPS_5V = 16'h3333;

    // ----------------------------------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_LOC_VSET = 8'h0c;
    localparam logic [7:0] REG_LOC_ISET = 8'h10;
    localparam logic [7:0] REG_LOC_PSET = 8'h14;
    localparam logic [7:0] REG_LOC_RSET = 8'h18;
    localparam logic [7:0] REG_OVP = 8'h1c;
    localparam logic [7:0] REG_ACT_VI = 8'h20;
    localparam logic [7:0] REG_ACT_PR = 8'h24;
    localparam logic [7:0] REG_MON = 8'h28;

    // Field positions
    localparam int unsigned CTRL_ALLOW_BIT = 0;
    localparam int unsigned CTRL_RANGE10_BIT = 1;
    localparam int unsigned CTRL_DC_ON_BIT = 2;
    localparam int unsigned CMD_REQ_BIT = 0;
    localparam int unsigned CMD_REL_BIT = 1;
    localparam int unsigned CMD_ACK_BIT = 2;
    localparam int unsigned STATUS_REFUSED_BIT = 4;

    // Reset values
    localparam logic ALLOW_RESET = 1'b1;
    localparam logic RANGE10_RESET = 1'b1;
    localparam logic DC_ON_RESET = 1'b0;
    localparam logic [15:0] SET_RESET = 16'h0000;
    localparam logic [15:0] OVP_RESET = 16'h6666;

    // Control location
    typedef enum logic [1:0] {LOC_MANUAL, LOC_REMOTE, LOC_LOCAL} rcar_loc_t;

    // Nominal-scale value to a code of the selected analog range
    function automatic logic [15:0] rcar_to_range(input logic [15:0] nominal, input logic range10);
        return range10 ? nominal : {1'b0, nominal[15:1]};
    endfunction

endpackage

// ### logic/rcar_setpoint_scale.sv
// Clips and scales one analog set input to the nominal step scale
`timescale 1ns/1ns
module rcar_setpoint_scale (
    input logic clk,
    input logic rst,
    input logic sample,
    input logic range10,
    input logic [15:0] code,
    output logic [15:0] value_reg
);
    import rcar_pkg::*;

    logic [15:0] full;
    logic [15:0] clipped;
    logic [15:0] value_next;

    // Saturate at full scale of the range, then bring to the common scale
    always_comb begin
        full = range10 ? STEPS_10V : STEPS_5V;
        clipped = (code > full) ? full : code;
        value_next = range10 ? clipped : {clipped[14:0], 1'b0};
    end

    // Only taken at the sample tick, so the input rate is bounded
    always_ff @(posedge clk) begin
        if (rst) begin
            value_reg <= SET_RESET;
        end else if (sample) begin
            value_reg <= value_next;
        end
    end

    clip_full_a: assert property (@(posedge clk) disable iff (rst)
        sample && (code >= (range10 ? STEPS_10V : STEPS_5V)) |=> value_reg == STEPS_10V)
        else $error("over-range input not saturated to full scale");

endmodule // rcar_setpoint_scale

// ### tb/rcar_ext_ctrl.sv
// Model of the external controller that drives the analog control port pins
`timescale 1ns/1ns
module rcar_ext_ctrl (
    input wire logic remote_on,
    input wire logic rmode_on,
    input wire logic ack_low,
    output logic remote_sel_n,
    output logic rmode_n,
    output logic standby,
    output logic [15:0] vset,
    output logic [15:0] iset,
    output logic [15:0] pset,
    output logic [15:0] rset
);
    // Pin low asks for analog control; standby drops only for the acknowledge pulse
    assign remote_sel_n = !remote_on;
    assign standby = !ack_low;
    assign rmode_n = !rmode_on;
    // Every set input is held at a defined level; current is over range on purpose
    assign vset = 16'h1234;
    assign iset = 16'h7000;
    assign pset = 16'h6666;
    assign rset = 16'h0100;
endmodule // rcar_ext_ctrl

// ### tb/tb.sv
// Self-checking testbench of the remote control arbiter
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; $display("FAIL %0t got %h", $time, a); end end
module tb;
    import rcar_pkg::*;
    logic MCLK = 0, RST = 1, HSEL = 0, HWRITE = 0, remote_on = 0, ack_low = 0, rmode_on = 0;
    logic [2:0] HSIZE = 3'h0;
    logic [3:0] alm = 4'h0;
    logic [31:0] act = 32'h0abc_1234;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, q;
    logic [1:0] HTRANS = 0;
    logic HREADYOUT, HRESP, rsn, rmn, sbp, ana, dig, derr, rmode, dcon, a1, a2;
    logic [15:0] vs, is, ps, rs, vi, ii, pi, ri, overvoltage_protection, vm, cm, refo;
    rcar_loc_t loc;
    int err_total = 0, total_checks = 0;
    always #5 MCLK = ~MCLK;
    rcar_ext_ctrl u_rcar_ext_ctrl (.remote_on(remote_on), .rmode_on(rmode_on), .ack_low(ack_low),
        .remote_sel_n(rsn), .rmode_n(rmn), .standby(sbp), .vset(vi), .iset(ii), .pset(pi), .rset(ri));
    rcar_arbiter #(.SAMPLE_CYCLES(8), .ACK_LOW_CYCLES(20)) u_rcar_arbiter (.MCLK(MCLK), .RST(RST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .REMOTE_SELECT_N(rsn), .RESISTANCE_MODE_N(rmn),
        .INPUT_STANDBY_PIN(sbp), .VOLTAGE_SETPOINT_INPUT(vi), .CURRENT_SETPOINT_INPUT(ii),
        .POWER_SETPOINT_INPUT(pi), .RESISTANCE_SETPOINT_INPUT(ri), .ACTUAL_VOLTAGE(act[15:0]),
        .ACTUAL_CURRENT(act[31:16]), .ALARM_OV_OC_OP(alm[2:0]), .ALARM_OT_PF(alm[3]), .LOCATION(loc),
        .ANALOG_ACTIVE(ana), .DIGITAL_ACTIVE(dig), .DIGITAL_REQ_ERROR(derr), .R_MODE(rmode), .VOLTAGE_SET(vs),
        .CURRENT_SET(is), .POWER_SET(ps), .RESISTANCE_SET(rs), .OVERVOLTAGE_PROTECTION(overvoltage_protection),
        .VOLTAGE_MONITOR_OUTPUT(vm), .CURRENT_MONITOR_OUTPUT(cm), .REFERENCE_OUTPUT(refo), .DC_INPUT_ON(dcon),
        .ALARM_OT_PF_OUT(a1), .ALARM_OV_OC_OP_OUT(a2));
    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    // Waits for hready; a hung slave ends the run
    task automatic rdy();
        int n;
        n = 0;
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                stop_test();
            end
            @(posedge MCLK);
        end
    endtask
    // One single word transfer; read data is taken at the data phase edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        HSIZE <= 3'b010;
        rdy();
        HTRANS <= 2'b00;
        HWDATA <= d;
        rdy();
        q = HRDATA;
    endtask
    task automatic wait_an(input logic v);
        int n;
        for (n = 0; n < 200 && ana !== v; n++) @(posedge MCLK);
        if (n == 200) begin
            err_total++;
            stop_test();
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        tick(4);
        RST <= 1'b0;
        tick(1);
        `CHK(loc, LOC_MANUAL)
        `CHK(refo, 16'h6666)
        xfer(1'b1, REG_CMD, 32'h1);
        tick(2);
        `CHK(dig, 1'b1)
        `CHK(loc, LOC_REMOTE)
        `CHK(vm, 16'h1234)
        `CHK(cm, 16'h0abc)
        // Analog pin pulled low while digital owns the load must change nothing
        remote_on <= 1'b1;
        tick(30);
        `CHK(ana, 1'b0)
        xfer(1'b1, REG_CTRL, 32'h2);
        tick(2);
        `CHK(loc, LOC_LOCAL)
        `CHK(dig, 1'b0)
        xfer(1'b1, REG_CTRL, 32'h3);
        wait_an(1'b1);
        `CHK(dig, 1'b0)
        tick(20);
        `CHK(vs, 16'h1234)
        `CHK(is, 16'h6666)
        `CHK(rs, 16'h0000)
        `CHK(overvoltage_protection, 16'h6666)
        `CHK(dcon, 1'b1)
        `CHK(ps, 16'h6666)
        `CHK(rmode, 1'b0)
        // Live and latched alarms in analog mode force the input off
        alm <= 4'h9;
        tick(6);
        `CHK(a1, 1'b1)
        alm <= 4'h0;
        tick(5);
        `CHK(a1, 1'b0)
        `CHK(a2, 1'b1)
        `CHK(dcon, 1'b0)
        // Standby low well past the acknowledge time, then high, clears the latch
        ack_low <= 1'b1;
        tick(40);
        `CHK(dcon, 1'b0)
        ack_low <= 1'b0;
        tick(30);
        `CHK(a2, 1'b0)
        `CHK(dcon, 1'b1)
        rmode_on <= 1'b1;
        tick(20);
        `CHK(rmode, 1'b1)
        `CHK(rs, 16'h0100)
        xfer(1'b1, REG_CMD, 32'h1);
        tick(2);
        `CHK(derr, 1'b1)
        `CHK(dig, 1'b0)
        xfer(1'b0, REG_STATUS, 32'h0);
        `CHK(q[4:2], 3'b101)
        `CHK(HRESP, 1'b0)
        xfer(1'b0, REG_MON, 32'h0);
        `CHK(q, 32'h0abc_1234)
        remote_on <= 1'b0;
        wait_an(1'b0);
        xfer(1'b1, REG_CTRL, 32'h1);
        tick(2);
        `CHK(refo, 16'h3333)
        `CHK(vm, 16'h091a)
        `CHK(cm, 16'h055e)
        stop_test();
    end
endmodule // tb
